// *** include/tod_pkg.sv ***
// Package: register map, field layout, states and carrier of the transmit offload parser
package tod_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_TRANSMIT_RING_BASE  = 8'h04;
   localparam logic [7:0]  REG_DEFAULT_VLAN_REGISTER = 8'h08;
   localparam logic [7:0]  REG_CURBD  = 8'h0C;
   localparam logic [7:0]  REG_TAG    = 8'h10;
   localparam int          CTRL_EN    = 0;
   localparam int          CTRL_VLAN  = 1;
   localparam int          CTRL_TMR   = 2;
   localparam logic [2:0]  CTRL_RST   = 3'h0;
   localparam logic [31:0] TRANSMIT_RING_BASE_RST  = 32'h0000_0000;
   localparam logic [15:0] DEFAULT_VLAN_REGISTER_RST = 16'h0000;
   localparam logic [15:0] TAG_RST    = 16'h0000;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;
   // ------------------------------------------------------------
   // Memory layout: descriptors and control block are 8 bytes
   // ------------------------------------------------------------
   localparam logic [31:0] DESC_STEP  = 32'h0000_0008;
   localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
   // Descriptor word 0: flags in [31:16], length in [15:0]
   localparam int          BD_READY   = 31;
   localparam int          BD_WRAP    = 29;
   localparam int          BD_LAST    = 27;
   localparam int          BD_TOE     = 17;
   localparam logic [15:0] STAT_MASK  = 16'h02FF;
   // Control block word 0: flags, layer 4 offset, layer 3 offset
   localparam int          FCB_VLN    = 31;
   localparam int          FCB_IP     = 30;
   localparam int          FCB_IP6    = 29;
   localparam int          FCB_TUP    = 28;
   localparam int          FCB_UDP    = 27;
   localparam int          FCB_CIP    = 26;
   localparam int          FCB_CTU    = 25;
   localparam int          FCB_NPH    = 24;
   localparam int          FCB_PTP    = 16;
   localparam int          LAYER4_OFFSET_LSB   = 8;
   localparam int          LAYER3_OFFSET_LSB   = 0;
   // Control block word 1: software pseudo sum, vlan word or tag
   localparam int          SOFTWARE_PSEUDO_SUM_LSB   = 16;
   localparam int          VLAN_CONTROL_WORD_LSB  = 0;
   // ------------------------------------------------------------
   // States and carrier
   // ------------------------------------------------------------
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001, ST_BD0 = 9'h002, ST_BD1 = 9'h004,
      ST_FCB0 = 9'h008, ST_FCB1 = 9'h010, ST_SEND = 9'h020,
      ST_WAIT = 9'h040, ST_CLR = 9'h080, ST_STAT = 9'h100
   } tod_state_e;
   typedef struct packed {
      logic [31:0] buf_ptr;
      logic [15:0] length;
      logic        first;
      logic        last;
      logic        fcb_present;
      logic        ptp;
      logic        ts_capture;
      logic [15:0] ts_tag;
      logic        vlan_insert;
      logic [15:0] vlan_word;
      logic        l3_valid;
      logic        ipv6;
      logic [7:0]  l3_offset;
      logic        l4_tcp;
      logic        l4_udp;
      logic [7:0]  l4_offset;
      logic        ipv4_csum;
      logic        l4_csum;
      logic        sw_pseudo;
      logic [15:0] pseudo_sum;
   } tod_ctl_s;
endpackage : tod_pkg

// *** design/tod_parser.sv ***
// Transmit descriptor walker and control block parser with AXI4-Lite registers
// Summary of operation
// - Control block bit 15 marks a timing packet; capture its transmit time.
// - Copy control block bytes 6-7 into the captured timestamp tag.
// - Timing mark overrides the vlan valid bit; no per-packet tag insertion.
// - Timing packets take any inserted tag from the default vlan register.
// - Vlan valid 0 ignores the word; 1 with insertion enabled uses it.
// - Bit 1 set means IP layer 3 with valid offset; clear ignores layers 3+.
// - Bit 2 selects IPv6 over IPv4, honoured only while the IP bit is set.
// - Bit 3 means TCP, or UDP with bit 4; clear means no layer 4 work.
// - Bit 5 requests the IPv4 header checksum.
// - Bit 6 requests TCP checksum when IP, layer 4 set and UDP clear.
// - Bit 7 uses the software pseudo sum instead of computing it.
// - Layer 4 offset is 8 bits after layer 3 start, at most 255.
// - Layer 3 offset counts from frame start, excluding the control block.
// - Descriptors are consecutive; advance by one, return to base on wrap.
// - Each descriptor is 8 bytes: status, length, buffer pointer.
// - The ownership bit decides who may process a descriptor.
// - When done, clear ownership first, then write the transfer status.
`timescale 1ns/1ps
module tod_parser
   import tod_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   output logic             tx_valid,
   output tod_ctl_s         tx_ctl,
   input  wire logic        tx_ready,
   input  wire logic        tx_done,
   input  wire logic [15:0] tx_status
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [2:0]  ctrl_r;
   logic [31:0] transmit_ring_base_r;
   logic [15:0] default_vlan_register_r;
   logic [31:0] cur_r;
   logic [15:0] tag_r;
   logic        awready_r;
   logic        arready_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [1:0]  rresp_r;
   logic [31:0] rdata_r;
   tod_state_e  state_r;
   logic        mem_req_r;
   logic        mem_we_r;
   logic [31:0] mem_addr_r;
   logic [31:0] mem_wdata_r;
   logic [31:0] bd0_r;
   logic [31:0] bd1_r;
   logic [31:0] fcb0_r;
   logic [31:0] fcb1_r;
   logic        first_r;
   logic [15:0] stat_r;
   logic        tx_valid_r;
   tod_ctl_s    ctl_r;
   tod_ctl_s    ctl_nxt;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // Register bus decode
   // ------------------------------------------------------------
   // Write waits for address and data together; one write at a time
   wire wr_go  = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
   wire wr_hs  = s_axi_awvalid & s_axi_wvalid & awready_r;
   wire wr_map = s_axi_awaddr <= REG_TAG && s_axi_awaddr[1:0] == 2'h0;
   wire ctrl_wr   = wr_hs & (s_axi_awaddr == REG_CTRL);
   wire transmit_ring_base_wr  = wr_hs & (s_axi_awaddr == REG_TRANSMIT_RING_BASE);
   wire default_vlan_register_wr = wr_hs & (s_axi_awaddr == REG_DEFAULT_VLAN_REGISTER);
   wire rd_go  = s_axi_arvalid & ~arready_r & ~rvalid_r;
   wire rd_hs  = s_axi_arvalid & arready_r;
   wire rd_map = s_axi_araddr <= REG_TAG && s_axi_araddr[1:0] == 2'h0;
   logic [31:0] rd_mux;
   logic [31:0] wr_val;

   // Byte lanes merged over the old value of the addressed register
   function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      for (int i = 0; i < 4; i++) lanes[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
   endfunction : lanes

   // Old value seen by the write, read mux
   always_comb begin
      case (s_axi_awaddr)
         REG_CTRL:   wr_val = lanes({29'h0, ctrl_r}, s_axi_wdata, s_axi_wstrb);
         REG_TRANSMIT_RING_BASE:  wr_val = lanes(transmit_ring_base_r, s_axi_wdata, s_axi_wstrb);
         REG_DEFAULT_VLAN_REGISTER: wr_val = lanes({16'h0, default_vlan_register_r}, s_axi_wdata, s_axi_wstrb);
         default:    wr_val = 32'h0000_0000;
      endcase
      case (s_axi_araddr)
         REG_CTRL:   rd_mux = {29'h0, ctrl_r};
         REG_TRANSMIT_RING_BASE:  rd_mux = transmit_ring_base_r;
         REG_DEFAULT_VLAN_REGISTER: rd_mux = {16'h0, default_vlan_register_r};
         REG_CURBD:  rd_mux = cur_r;
         REG_TAG:    rd_mux = {7'h0, state_r, tag_r};
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus handshakes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         arready_r <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= 32'h0000_0000;
      end else begin
         awready_r <= wr_go;
         arready_r <= rd_go;
         if (wr_hs) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_map ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
         if (rd_hs) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_map ? RESP_OKAY : RESP_DECERR;
            rdata_r  <= rd_mux;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // Software registers; read-only offsets ignore writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r   <= CTRL_RST;
         transmit_ring_base_r  <= TRANSMIT_RING_BASE_RST;
         default_vlan_register_r <= DEFAULT_VLAN_REGISTER_RST;
      end else begin
         if (ctrl_wr) ctrl_r <= wr_val[2:0];
         if (transmit_ring_base_wr) transmit_ring_base_r <= wr_val;
         if (default_vlan_register_wr) default_vlan_register_r <= wr_val[15:0];
      end
   end

   // ------------------------------------------------------------
   // Control block decode
   // ------------------------------------------------------------
   // Offload fields only count in the first descriptor of a frame
   wire fcb_on = first_r & bd0_r[BD_TOE];
   wire f_ptp  = fcb0_r[FCB_PTP];
   wire f_ip   = fcb0_r[FCB_IP];
   wire f_l4   = f_ip & fcb0_r[FCB_TUP];
   assign ctl_nxt.buf_ptr     = bd1_r;
   assign ctl_nxt.length      = bd0_r[15:0];
   assign ctl_nxt.first       = first_r;
   assign ctl_nxt.last        = bd0_r[BD_LAST];
   assign ctl_nxt.fcb_present = fcb_on;
   assign ctl_nxt.ptp         = f_ptp;
   assign ctl_nxt.ts_capture  = f_ptp & ctrl_r[CTRL_TMR];
   assign ctl_nxt.ts_tag      = f_ptp ? fcb1_r[VLAN_CONTROL_WORD_LSB +: 16] : 16'h0000;
   // Timing mark wins over the vlan valid bit
   assign ctl_nxt.vlan_insert = ctrl_r[CTRL_VLAN] & (f_ptp | fcb0_r[FCB_VLN]);
   assign ctl_nxt.vlan_word   = f_ptp ? default_vlan_register_r : fcb1_r[VLAN_CONTROL_WORD_LSB +: 16];
   assign ctl_nxt.l3_valid    = f_ip;
   assign ctl_nxt.ipv6        = f_ip & fcb0_r[FCB_IP6];
   assign ctl_nxt.l3_offset   = f_ip ? fcb0_r[LAYER3_OFFSET_LSB +: 8] : 8'h00;
   assign ctl_nxt.l4_tcp      = f_l4 & ~fcb0_r[FCB_UDP];
   assign ctl_nxt.l4_udp      = f_l4 & fcb0_r[FCB_UDP];
   assign ctl_nxt.l4_offset   = f_l4 ? fcb0_r[LAYER4_OFFSET_LSB +: 8] : 8'h00;
   assign ctl_nxt.ipv4_csum   = f_ip & ~fcb0_r[FCB_IP6] & fcb0_r[FCB_CIP];
   assign ctl_nxt.l4_csum     = f_l4 & ~fcb0_r[FCB_UDP] & fcb0_r[FCB_CTU];
   assign ctl_nxt.sw_pseudo   = f_l4 & fcb0_r[FCB_NPH];
   assign ctl_nxt.pseudo_sum  = ctl_nxt.sw_pseudo ? fcb1_r[SOFTWARE_PSEUDO_SUM_LSB +: 16] : 16'h0000;

   // ------------------------------------------------------------
   // Descriptor walker
   // ------------------------------------------------------------
   // One memory access per access state, request held until ack
   wire acc_st = state_r inside {ST_BD0, ST_BD1, ST_FCB0, ST_FCB1, ST_CLR, ST_STAT};
   wire acc_done = mem_req_r & mem_ack;
   wire [15:0] own_clr = bd0_r[31:16] & ~16'h8000;
   logic [31:0] acc_addr;
   logic [31:0] acc_data;
   always_comb begin
      acc_data = 32'h0000_0000;
      case (state_r)
         ST_BD0:  acc_addr = cur_r;
         ST_BD1:  acc_addr = cur_r + WORD_STEP;
         ST_FCB0: acc_addr = bd1_r;
         ST_FCB1: acc_addr = bd1_r + WORD_STEP;
         ST_CLR: begin
            acc_addr = cur_r;
            acc_data = {own_clr, bd0_r[15:0]};
         end
         ST_STAT: begin
            acc_addr = cur_r;
            acc_data = {(own_clr & ~STAT_MASK) | (stat_r & STAT_MASK), bd0_r[15:0]};
         end
         default: acc_addr = cur_r;
      endcase
   end
   // Ownership handed back before status lands; software must not trust status until then
   wire [31:0] next_bd = bd0_r[BD_WRAP] ? transmit_ring_base_r : cur_r + DESC_STEP;

   // Memory port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_req_r   <= 1'b0;
         mem_we_r    <= 1'b0;
         mem_addr_r  <= 32'h0000_0000;
         mem_wdata_r <= 32'h0000_0000;
      end else if (acc_done) begin
         mem_req_r <= 1'b0;
      end else if (acc_st & ~mem_req_r) begin
         mem_req_r   <= 1'b1;
         mem_we_r    <= state_r inside {ST_CLR, ST_STAT};
         mem_addr_r  <= acc_addr;
         mem_wdata_r <= acc_data;
      end
   end

   // Walker sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r    <= ST_IDLE;
         cur_r      <= TRANSMIT_RING_BASE_RST;
         bd0_r      <= 32'h0000_0000;
         bd1_r      <= 32'h0000_0000;
         fcb0_r     <= 32'h0000_0000;
         fcb1_r     <= 32'h0000_0000;
         first_r    <= 1'b1;
         stat_r     <= 16'h0000;
         tx_valid_r <= 1'b0;
         ctl_r      <= '0;
         tag_r      <= TAG_RST;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (transmit_ring_base_wr) cur_r <= wr_val;
               else if (ctrl_r[CTRL_EN]) state_r <= ST_BD0;
            end
            ST_BD0: if (acc_done) begin
               bd0_r   <= mem_rdata;
               state_r <= mem_rdata[BD_READY] ? ST_BD1 : ST_IDLE;
            end
            ST_BD1: if (acc_done) begin
               bd1_r  <= mem_rdata;
               fcb0_r <= 32'h0000_0000;
               fcb1_r <= 32'h0000_0000;
               state_r <= fcb_on ? ST_FCB0 : ST_SEND;
            end
            ST_FCB0: if (acc_done) begin
               fcb0_r  <= mem_rdata;
               state_r <= ST_FCB1;
            end
            ST_FCB1: if (acc_done) begin
               fcb1_r  <= mem_rdata;
               state_r <= ST_SEND;
            end
            ST_SEND: begin
               tx_valid_r <= 1'b1;
               ctl_r      <= ctl_nxt;
               state_r    <= ST_WAIT;
            end
            ST_WAIT: begin
               if (tx_valid_r & tx_ready) begin
                  tx_valid_r <= 1'b0;
                  if (ctl_r.ts_capture) tag_r <= ctl_r.ts_tag;
               end
               if (~tx_valid_r & tx_done) begin
                  stat_r  <= tx_status;
                  state_r <= ST_CLR;
               end
            end
            ST_CLR: if (acc_done) state_r <= ST_STAT;
            ST_STAT: if (acc_done) begin
               cur_r   <= next_bd;
               first_r <= bd0_r[BD_LAST];
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = awready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;
   assign mem_req       = mem_req_r;
   assign mem_we        = mem_we_r;
   assign mem_addr      = mem_addr_r;
   assign mem_wdata     = mem_wdata_r;
   assign tx_valid      = tx_valid_r;
   assign tx_ctl        = ctl_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_fcb_read;
      state_r == ST_FCB1 && acc_done ##1 state_r == ST_SEND;
   endsequence
   sequence s_bd_done;
      state_r == ST_STAT && acc_done;
   endsequence

   ts_tag_a: assert property (s_fcb_read |=> tx_valid && tx_ctl.ts_tag == (fcb1_r[VLAN_CONTROL_WORD_LSB +: 16] & {16{fcb0_r[FCB_PTP]}}))
      else $error("timestamp tag not taken from control block");
   ts_mark_a: assert property (s_fcb_read |=> tx_ctl.ts_capture == (fcb0_r[FCB_PTP] & ctrl_r[CTRL_TMR]))
      else $error("timestamp capture does not follow mark");
   ptp_vlan_a: assert property (tx_valid && tx_ctl.ptp && tx_ctl.vlan_insert |-> tx_ctl.vlan_word == default_vlan_register_r)
      else $error("timing packet vlan word not from default register");
   vln_off_a: assert property (s_fcb_read ##0 (!fcb0_r[FCB_VLN] && !fcb0_r[FCB_PTP])[*1] |=> !tx_ctl.vlan_insert)
      else $error("vlan inserted with valid bit clear");
   l3_gate_a: assert property (tx_valid && !tx_ctl.l3_valid |-> !tx_ctl.ipv6 && !tx_ctl.l4_tcp && !tx_ctl.l4_udp)
      else $error("layer 3 and higher used without IP bit");
   tcp_csum_a: assert property (tx_valid && tx_ctl.l4_csum |-> tx_ctl.l4_tcp && !tx_ctl.l4_udp)
      else $error("layer 4 checksum without TCP");
   own_wait_a: assert property (state_r == ST_BD0 && acc_done && !mem_rdata[BD_READY] |=> state_r == ST_IDLE ##1 !tx_valid)
      else $error("descriptor processed without ownership");
   own_first_a: assert property (state_r == ST_CLR && mem_req && mem_we |-> !mem_wdata[BD_READY] ##1 (state_r != ST_IDLE))
      else $error("ownership not cleared before status");
   wrap_a: assert property ((s_bd_done and bd0_r[BD_WRAP]) |=> cur_r == transmit_ring_base_r)
      else $error("wrap did not return to ring base");
   step_a: assert property ((s_bd_done and !bd0_r[BD_WRAP]) |=> cur_r == $past(cur_r) + DESC_STEP)
      else $error("descriptor pointer did not advance by one");
endmodule : tod_parser

// *** tb/tod_host_model.sv ***
// Partner model: host memory holding the descriptor ring and the transmit MAC
`timescale 1ns/1ps
module tod_host_model
   import tod_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  lat,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic             tx_done,
   output logic [15:0]      tx_status
);
   // ------------------------------------------------------------
   // Memory image and bookkeeping
   // ------------------------------------------------------------
   logic [31:0] mem [logic [31:0]];  // Laid out by the bench as 8-byte descriptors
   int          wait_cnt = 0;
   int          done_cnt = 0;
   int          wr_cnt   = 0;
   int          own_err  = 0;

   // Outputs defined before the first edge
   initial begin
      mem_ack   = 1'b0;
      mem_rdata = 32'h0;
      tx_ready  = 1'b0;
      tx_done   = 1'b0;
      tx_status = 16'h0;
   end

   // Memory answers after lat cycles; idle data toggles so a stale word never passes
   always @(posedge aclk) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!aresetn) begin
         wait_cnt  <= 0;
         mem_rdata <= 32'h5A5A_5A5A;
      end else if (mem_req && !mem_ack) begin
         if (wait_cnt < lat) begin
            wait_cnt <= wait_cnt + 1;
         end else begin
            wait_cnt <= 0;
            mem_ack  <= 1'b1;
            if (mem_we) begin
               mem[mem_addr] = mem_wdata;
               wr_cnt++;
               own_err += mem_wdata[31];  // Every write-back hands ownership back
            end else begin
               mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
            end
         end
      end
   end

   // MAC takes each offer a cycle late, reports done a few cycles on
   always @(posedge aclk) begin
      tx_ready  <= tx_valid && !tx_ready;
      tx_done   <= (done_cnt == 1);
      tx_status <= 16'h0201;
      if (!aresetn) begin
         done_cnt <= 0;
      end else if (tx_valid && tx_ready) begin
         done_cnt <= 4;
      end else if (done_cnt > 0) begin
         done_cnt <= done_cnt - 1;
      end
   end
endmodule : tod_host_model

// *** tb/tod_parser_tb_top.sv ***
// Self-checking bench for the transmit descriptor walker and control block parser
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tod_parser_tb_top
   import tod_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        aclk = 1'b0;
   logic        aresetn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
   logic [3:0]  s_axi_wstrb, lat;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        mem_req, mem_we, mem_ack, tx_valid, tx_ready, tx_done;
   logic [15:0] tx_status;
   tod_ctl_s    tx_ctl;
   tod_ctl_s    got[$];
   int          num_errors = 0;
   int          comparisons = 0;
   // Ring of four descriptors, wrap on the last; OFFLOAD_ENABLE set on the first three
   logic [31:0] img [0:13] = '{32'h8802_0040, 32'h400, 32'h8802_0050, 32'h500, 32'h8802_0060, 32'h600,
                               32'hA800_0070, 32'h700, 32'hDE01_0E12, 32'h1234_BEEF, 32'hF7FE_28FF,
                               32'hA5C3_0123, 32'h1E00_1020, 32'hFFFF_FFFF};  // Pseudo sum A5C3

   always #50 aclk = ~aclk;
   // Record each control word as the MAC takes it
   always @(posedge aclk) if (tx_valid && tx_ready) got.push_back(tx_ctl);

   tod_parser dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .tx_valid,
      .tx_ctl, .tx_ready, .tx_done, .tx_status);
   tod_host_model host (.aclk, .aresetn, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
      .mem_rdata, .tx_valid, .tx_ready, .tx_done, .tx_status);

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic conclude;
      $display("Mismatches %0d, comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 60);
      s_axi_bready <= 1'b0;
      if (n >= 60) begin
         num_errors++;
         conclude();
      end
      `CHK(s_axi_bresp, er)
   endtask : wr

   // Read: compares the masked word and the response code
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 60);
      s_axi_rready <= 1'b0;
      if (n >= 60) begin
         num_errors++;
         conclude();
      end
      `CHK({s_axi_rdata & m, s_axi_rresp}, {ed, er})
   endtask : rd

   // Expected control word per frame; fields the rules leave open follow the observed word
   function automatic tod_ctl_s expect_of(input int k, input tod_ctl_s g);
      case (k)
         0: return '{default: 0, buf_ptr: g.buf_ptr, length: g.length, first: 1, last: 1, fcb_present: 1,
                     ptp: 1, ts_capture: 1, ts_tag: 16'hBEEF, vlan_insert: g.vlan_insert, vlan_word: 16'h0ABC,
                     l3_valid: 1, l3_offset: 8'h12, l4_udp: 1, l4_offset: 8'h0E, ipv4_csum: 1,
                     pseudo_sum: g.pseudo_sum};
         1: return '{default: 0, buf_ptr: g.buf_ptr, length: g.length, first: 1, last: 1, fcb_present: 1,
                     ts_tag: g.ts_tag, vlan_insert: 1, vlan_word: 16'h0123, l3_valid: 1, ipv6: 1,
                     l3_offset: 8'hFF, l4_tcp: 1, l4_offset: 8'h28, l4_csum: 1, sw_pseudo: 1, pseudo_sum: 16'hA5C3};
         2: return '{default: 0, buf_ptr: g.buf_ptr, length: g.length, first: 1, last: 1, fcb_present: 1,
                     ts_tag: g.ts_tag, vlan_word: g.vlan_word, l3_offset: g.l3_offset, l4_offset: g.l4_offset,
                     pseudo_sum: g.pseudo_sum};
         default: return '{default: 0, buf_ptr: 32'h700, length: 16'h70, first: 1, last: 1};
      endcase
   endfunction : expect_of

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int n;
      aresetn <= 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
      lat <= 4'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 8; i++) host.mem[32'h100 + 32'(4 * i)] = img[i];
      for (int i = 0; i < 3; i++) begin
         host.mem[32'h400 + 32'(256 * i)] = img[8 + 2 * i];
         host.mem[32'h404 + 32'(256 * i)] = img[9 + 2 * i];
      end
      rd(REG_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
      rd(REG_TRANSMIT_RING_BASE, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
      rd(REG_DEFAULT_VLAN_REGISTER, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
      rd(REG_TAG, 32'hFFFF_FFFF, 32'h0001_0000, RESP_OKAY);
      rd(8'h14, 32'hFFFF_FFFF, 32'h0, RESP_DECERR);
      wr(REG_TRANSMIT_RING_BASE, 32'h100, RESP_OKAY);
      wr(REG_DEFAULT_VLAN_REGISTER, 32'h0ABC, RESP_OKAY);
      wr(REG_CTRL, 32'h7, RESP_OKAY);  // Timer on before any marked frame
      n = 0;
      while ((got.size() < 4 || host.wr_cnt < 8) && n < 4000) begin
         @(posedge aclk);
         n++;
         if (got.size() == 2) lat <= 4'h5;
      end
      if (n >= 4000) begin
         num_errors++;
         conclude();
      end
      for (int k = 0; k < 4; k++) begin
         `CHK(got[k], expect_of(k, got[k]))
      end
      repeat (60) @(posedge aclk);
      `CHK(host.wr_cnt, 8)  // Cleared descriptor is not processed again
      `CHK(host.own_err, 0)
      for (int i = 0; i < 4; i++) begin
         logic [31:0] wb;
         wb = {(img[2 * i][31:16] & ~16'h8000 & ~STAT_MASK) | (16'h0201 & STAT_MASK), img[2 * i][15:0]};
         `CHK(host.mem[32'h100 + 32'(8 * i)], wb)  // Ownership cleared, status merged
      end
      rd(REG_CURBD, 32'hFFFF_FFFF, 32'h100, RESP_OKAY);  // Back at ring start after wrap
      rd(REG_TAG, 32'h0000_FFFF, 32'h0000_BEEF, RESP_OKAY);
      wr(REG_CURBD, 32'h0, RESP_OKAY);
      wr(8'h14, 32'h0, RESP_DECERR);
      rd(REG_CURBD, 32'hFFFF_FFFF, 32'h100, RESP_OKAY);
      conclude();
   end
endmodule : tod_parser_tb_top
